// ### logic/smq_regs.svh
// Purpose: constants for the sc1 maintenance message scheduler
// Assumes: 250 MHz clock
// Notes:   times in their own unit, cycle counts derived
`ifndef SMQ_REGS_SVH
`define SMQ_REGS_SVH
`define SMQ_CLK_MHZ        250
`define SMQ_TICK_MS        30
`define SMQ_TICK_CYCLES    (`SMQ_TICK_MS * 1000 * `SMQ_CLK_MHZ)
`define SMQ_MSG_W          4
`define SMQ_HP_DEPTH       2
`define SMQ_MSG_RST        4'hf
`define SMQ_MF_FRAMES      20
`endif

// ### logic/smq_pkg.sv
// Purpose: types for the sc1 maintenance message scheduler
// Assumes: smq_regs.svh constants
// Notes:   none
`include "smq_regs.svh"
package smq_pkg;
  typedef logic [`SMQ_MSG_W-1:0] smq_msg_t;
  typedef enum logic {SMQ_SRC_LOW, SMQ_SRC_HIGH} smq_src_t;
endpackage

// ### logic/smq_tick_gen.sv
// Purpose: periodic multiframe tick
// Assumes: enable is a level from same clock
// Notes:   one-cycle pulse every tickCycles
`timescale 1ns/1ps
`include "smq_regs.svh"
module smq_tick_gen
  import smq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SMQ_TICK_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } smq_tg_t;
  smq_tg_t s_r;
  smq_tg_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!enable) begin
      s_nxt.cnt = 32'h0;
    end else if (s_r.cnt == 32'(TICK_CYCLES - 1)) begin
      s_nxt.cnt = 32'h0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tick = s_r.tick;
  a_tick_period: assert property (@(posedge clock) disable iff (!rst_n)
    s_r.tick && enable |=> !s_r.tick [*8]) else $error("tick repeated early");
endmodule // smq_tick_gen

// ### logic/smq_scheduler.sv
// Purpose: selects the sc1 message sent each multiframe
// Assumes: frame strobe and loop error are same-clock pulses from the framer
// Notes:   high queue two deep, low register repeats
// Summary of operation
// - After the tick-enable command the block pulses a tick interrupt every 30 ms.
// - Message storage is a two-entry high fifo and one low register, all 4-bit codes.
// - The high queue holds two codes in order, each sent for one multiframe.
// - At each boundary the oldest high code is sent, else the low register.
// - A third high write while full shifts entry two to one and stores the new code second.
// - A loop code violation raises the received multiframe error indication.
`timescale 1ns/1ps
`include "smq_regs.svh"
module smq_scheduler
  import smq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SMQ_TICK_CYCLES,
  parameter int unsigned MF_FRAMES   = `SMQ_MF_FRAMES
) (
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     tickEnableCmd,
  input  wire logic     lowWrite,
  input  wire smq_msg_t lowData,
  input  wire logic     highWrite,
  input  wire smq_msg_t highData,
  input  wire logic     frameStrobe,
  input  wire logic     codeViolation,
  input  wire logic     errorClear,
  output smq_msg_t      txMsg,
  output logic          txIsHigh,
  output logic          multiframeStart,
  output logic          multiframeTickInterrupt,
  output logic          receivedMultiframeError,
  output logic [1:0]    highLevel
);
  typedef struct packed {
    logic       tickEn;
    smq_msg_t   low;
    smq_msg_t   hp0;
    smq_msg_t   hp1;
    logic [1:0] cnt;
    logic [7:0] frame;
    smq_msg_t   tx;
    smq_src_t   src;
    logic       mfStart;
    logic       tickIrq;
    logic       received_multiframe_error;
  } smq_st_t;
  smq_st_t s_r;
  smq_st_t s_nxt;
  logic    tick;
  logic    boundary;
  assign boundary = frameStrobe && (s_r.frame == 8'(MF_FRAMES - 1));
  smq_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clock  (clock),
    .rst_n  (rst_n),
    .enable (s_r.tickEn),
    .tick   (tick)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.mfStart = 1'b0;
    s_nxt.tickIrq = tick;
    if (tickEnableCmd) begin
      s_nxt.tickEn = 1'b1;
    end
    if (lowWrite) begin
      s_nxt.low = lowData;
    end
    if (frameStrobe) begin
      s_nxt.frame = boundary ? 8'h0 : s_r.frame + 8'h1;
    end
    if (boundary) begin
      s_nxt.mfStart = 1'b1;
      if (s_r.cnt != 2'h0) begin
        s_nxt.tx = s_r.hp0;
        s_nxt.src = SMQ_SRC_HIGH;
        s_nxt.hp0 = s_r.hp1;
        s_nxt.cnt = s_r.cnt - 2'h1;
      end else begin
        s_nxt.tx = s_r.low;
        s_nxt.src = SMQ_SRC_LOW;
      end
    end
    if (highWrite) begin
      case (s_nxt.cnt)
        2'h0: begin
          s_nxt.hp0 = highData;
          s_nxt.cnt = 2'h1;
        end
        2'h1: begin
          s_nxt.hp1 = highData;
          s_nxt.cnt = 2'h2;
        end
        default: begin
          s_nxt.hp0 = s_nxt.hp1;
          s_nxt.hp1 = highData;
          s_nxt.cnt = 2'h2;
        end
      endcase
    end
    if (errorClear) begin
      s_nxt.received_multiframe_error = 1'b0;
    end
    if (codeViolation) begin
      s_nxt.received_multiframe_error = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '{
        tickEn:  1'b0,
        low:     `SMQ_MSG_RST,
        hp0:     '0,
        hp1:     '0,
        cnt:     2'h0,
        frame:   8'h0,
        tx:      `SMQ_MSG_RST,
        src:     SMQ_SRC_LOW,
        mfStart: 1'b0,
        tickIrq: 1'b0,
        received_multiframe_error:    1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  assign txMsg = s_r.tx;
  assign txIsHigh = (s_r.src == SMQ_SRC_HIGH);
  assign multiframeStart = s_r.mfStart;
  assign multiframeTickInterrupt = s_r.tickIrq;
  assign receivedMultiframeError = s_r.received_multiframe_error;
  assign highLevel = s_r.cnt;

  a_high_first: assert property (@(posedge clock) disable iff (!rst_n)
    boundary && s_r.cnt != 2'h0 |=> txMsg == $past(s_r.hp0) && txIsHigh)
    else $error("queued high code not sent");
  a_low_repeat: assert property (@(posedge clock) disable iff (!rst_n)
    boundary && s_r.cnt == 2'h0 |=> txMsg == $past(s_r.low) && !txIsHigh)
    else $error("low code not repeated");
  a_queue_bound: assert property (@(posedge clock) disable iff (!rst_n)
    s_r.cnt <= 2'h2)
    else $error("queue over two");
  a_full_shift: assert property (@(posedge clock) disable iff (!rst_n)
    highWrite && !boundary && s_r.cnt == 2'h2 |=> s_r.hp0 == $past(s_r.hp1)
    && s_r.hp1 == $past(highData)) else $error("full write not shifted");
  a_one_frame: assert property (@(posedge clock) disable iff (!rst_n)
    boundary && s_r.cnt == 2'h1 && !highWrite |=> s_r.cnt == 2'h0)
    else $error("high code sent twice");
  a_error_set: assert property (@(posedge clock) disable iff (!rst_n)
    codeViolation |=> receivedMultiframeError)
    else $error("error lost");
  a_low_store: assert property (@(posedge clock) disable iff (!rst_n)
    lowWrite |=> s_r.low == $past(lowData))
    else $error("low not stored");
  a_tick_gate: assert property (@(posedge clock) disable iff (!rst_n)
    !s_r.tickEn |-> ##2 !multiframeTickInterrupt || $past(s_r.tickEn, 2))
    else $error("tick while disabled");
  a_tick_follow: assert property (@(posedge clock) disable iff (!rst_n)
    tick |=> multiframeTickInterrupt)
    else $error("tick not passed on");
  a_tick_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    multiframeTickInterrupt |=> !multiframeTickInterrupt)
    else $error("tick wider than a cycle");
  a_enable_set: assert property (@(posedge clock) disable iff (!rst_n)
    tickEnableCmd |=> s_r.tickEn)
    else $error("tick enable not taken");
  a_enable_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    s_r.tickEn |=> s_r.tickEn)
    else $error("tick enable dropped");
  a_tick_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    !s_r.tickEn |-> !tick)
    else $error("tick before enable");
  a_start_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    boundary |=> multiframeStart)
    else $error("boundary not flagged");
  a_start_only: assert property (@(posedge clock) disable iff (!rst_n)
    !boundary |=> !multiframeStart)
    else $error("start without boundary");
  a_tx_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !boundary |=> $stable(txMsg) && $stable(txIsHigh))
    else $error("message changed mid multiframe");
  a_low_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !lowWrite |=> $stable(s_r.low))
    else $error("low register changed unwritten");
  a_push_empty: assert property (@(posedge clock) disable iff (!rst_n)
    highWrite && !boundary && s_r.cnt == 2'h0 |=> s_r.cnt == 2'h1
    && s_r.hp0 == $past(highData)) else $error("first entry not stored");
  a_push_one: assert property (@(posedge clock) disable iff (!rst_n)
    highWrite && !boundary && s_r.cnt == 2'h1 |=> s_r.cnt == 2'h2
    && s_r.hp1 == $past(highData) && $stable(s_r.hp0)) else $error("second entry lost");
  a_pop_push: assert property (@(posedge clock) disable iff (!rst_n)
    boundary && highWrite && s_r.cnt == 2'h2 |=> s_r.cnt == 2'h2
    && s_r.hp0 == $past(s_r.hp1) && s_r.hp1 == $past(highData)) else $error("pop push wrong");
  a_pop_count: assert property (@(posedge clock) disable iff (!rst_n)
    boundary && s_r.cnt == 2'h2 && !highWrite |=> s_r.cnt == 2'h1
    && s_r.hp0 == $past(s_r.hp1)) else $error("pop from full wrong");
  a_empty_stay: assert property (@(posedge clock) disable iff (!rst_n)
    s_r.cnt == 2'h0 && !highWrite |=> s_r.cnt == 2'h0)
    else $error("empty queue filled");
  a_error_hold: assert property (@(posedge clock) disable iff (!rst_n)
    receivedMultiframeError && !errorClear |=> receivedMultiframeError)
    else $error("error dropped uncleared");
  a_error_clear: assert property (@(posedge clock) disable iff (!rst_n)
    errorClear && !codeViolation |=> !receivedMultiframeError)
    else $error("error not cleared");
  a_frame_range: assert property (@(posedge clock) disable iff (!rst_n)
    s_r.frame < 8'(MF_FRAMES))
    else $error("frame count out of range");
  a_frame_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !frameStrobe |=> $stable(s_r.frame))
    else $error("frame count moved");
  a_frame_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    boundary |=> s_r.frame == 8'h0)
    else $error("frame count not wrapped");
  a_frame_step: assert property (@(posedge clock) disable iff (!rst_n)
    frameStrobe && !boundary |=> s_r.frame == $past(s_r.frame) + 8'h1)
    else $error("frame count not stepped");
endmodule // smq_scheduler

// ### tb/smq_far_end.sv
// Purpose: terminal side model, frame pacing and loop errors
// Assumes: one frame every FRAME_GAP clocks
// Notes:   strobe held low in reset
`timescale 1ns/1ps
module smq_far_end #(
  parameter int FRAME_GAP = 4
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic injectCv,
  output logic      frameStrobe,
  output logic      codeViolation
);
  int cnt;
  always @(posedge clock) begin
    cnt <= (!rst_n || cnt == FRAME_GAP - 1) ? 0 : cnt + 1;
    frameStrobe <= rst_n && cnt == FRAME_GAP - 1;
    codeViolation <= rst_n && injectCv;
  end
endmodule // smq_far_end

// ### tb/smq_sched_test.sv
// Purpose: random and directed checks of the scheduler
// Assumes: 20-cycle tick, 3 frames a multiframe
// Notes:   reference model runs beside the design
`timescale 1ns/1ps
module sc1_maintenance_msg_scheduler_test;
  import smq_pkg::*;
  localparam int TK = 20;
  localparam int MF = 3;
  logic clock = 0, rst_n = 0, tickEnableCmd = 0, lowWrite = 0, highWrite = 0;
  logic errorClear = 0, injectCv = 0, dir = 0, frameStrobe, codeViolation;
  logic txIsHigh, multiframeStart, multiframeTickInterrupt, receivedMultiframeError;
  logic eHigh, eStart, eErr;
  logic [1:0] highLevel;
  smq_msg_t lowData = 4'h0, highData = 4'h0, txMsg, low, eMsg;
  smq_msg_t q[$];
  logic [31:0] r = 32'h1b76;
  int n_fail = 0, cmp_count = 0, fc, gap = 0, en = 0, ticks = 0, pick = 0;
  // message codes, values arbitrary
  localparam smq_msg_t selfTestReportMsg = 4'h1, loopbackIndicationMsg = 4'h2;
  localparam smq_msg_t lineReadyStatusMsg = 4'h3, lossOfSignalIndicationMsg = 4'h4;
  localparam smq_msg_t idleMsg = 4'h5, lossOfPowerMsg = 4'h6;
  localparam smq_msg_t farEndCodeViolationMsg = 4'h7, testSignalElementMsg = 4'h8;
  smq_msg_t lowCodes [5] = '{selfTestReportMsg, loopbackIndicationMsg,
    lineReadyStatusMsg, lossOfSignalIndicationMsg, idleMsg};
  logic [4:0] lowFlags = 5'h0;
  logic extendLowMsgFlag = 0;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
  always #2 clock = ~clock;
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  smq_scheduler #(.TICK_CYCLES(TK), .MF_FRAMES(MF)) uut (.clock(clock), .rst_n(rst_n),
    .tickEnableCmd(tickEnableCmd), .lowWrite(lowWrite), .lowData(lowData),
    .highWrite(highWrite), .highData(highData), .frameStrobe(frameStrobe),
    .codeViolation(codeViolation), .errorClear(errorClear), .txMsg(txMsg),
    .txIsHigh(txIsHigh), .multiframeStart(multiframeStart), .highLevel(highLevel),
    .multiframeTickInterrupt(multiframeTickInterrupt),
    .receivedMultiframeError(receivedMultiframeError));
  smq_far_end pe (.clock(clock), .rst_n(rst_n), .injectCv(injectCv),
    .frameStrobe(frameStrobe), .codeViolation(codeViolation));
  always @(posedge clock) if (rst_n && !dir) begin
    r = lfsr(r);
    highWrite <= &r[2:0];
    highData <= r[7:4];
    lowWrite <= &r[9:8] & r[3];
    lowData <= r[13:10];
    errorClear <= &r[16:14];
    injectCv <= &r[20:17];
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      q.delete();
      low = 4'hf;
      eMsg = 4'hf;
      {eHigh, eStart, eErr, fc} = 0;
    end else begin
      if (tickEnableCmd) en = 1;
      eStart = frameStrobe && fc == MF - 1;
      if (frameStrobe) fc = (fc == MF - 1) ? 0 : fc + 1;
      if (eStart) begin
        eHigh = q.size() != 0;
        eMsg = eHigh ? q.pop_front() : low;
      end
      if (highWrite) begin
        if (q.size() == 2) void'(q.pop_front());
        q.push_back(highData);
      end
      if (lowWrite) low = lowData;
      eErr = codeViolation || (eErr && !errorClear);
    end
  end
  always @(negedge clock) if (rst_n) begin
    `CHK(txMsg, eMsg)
    `CHK(txIsHigh, eHigh)
    `CHK(multiframeStart, eStart)
    `CHK(highLevel, 2'(q.size()))
    `CHK(receivedMultiframeError, eErr)
    if (multiframeTickInterrupt) begin
      `CHK(en, 1)
      if (ticks > 0) `CHK(gap, TK - 1)
      ticks++;
      gap = 0;
    end else gap++;
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1;
    repeat (300) @(posedge clock);
    tickEnableCmd <= 1;
    @(posedge clock);
    tickEnableCmd <= 0;
    repeat (2000) @(posedge clock);
    dir <= 1;
    @(posedge clock);
    lowWrite <= 0;
    injectCv <= 0;
    errorClear <= 1;
    for (int i = 0; i < 3; i++) begin
      highWrite <= 1;
      highData <= 4'(i + 9);
      @(posedge clock);
    end
    highWrite <= 0;
    repeat (40) @(posedge clock);
    errorClear <= 0;
    injectCv <= 1;
    @(posedge clock);
    injectCv <= 0;
    @(posedge clock iff receivedMultiframeError);
    highWrite <= 1;
    highData <= farEndCodeViolationMsg;
    extendLowMsgFlag = 1;
    @(posedge clock);
    highData <= testSignalElementMsg;
    @(posedge clock);
    highData <= lossOfPowerMsg;
    lowWrite <= 1;
    lowData <= lossOfPowerMsg;
    @(posedge clock);
    highWrite <= 0;
    lowWrite <= 0;
    errorClear <= 1;
    lowFlags = 5'h1f;
    repeat (7) begin
      @(posedge clock iff multiframeTickInterrupt);
      if (extendLowMsgFlag) extendLowMsgFlag = 0;
      else if (lowFlags != 5'h0) begin
        for (int i = 4; i >= 0; i--) if (lowFlags[i]) pick = i;
        lowWrite <= 1;
        lowData <= lowCodes[pick];
        lowFlags[pick] = 1'b0;
        @(posedge clock);
        lowWrite <= 0;
      end
    end
    repeat (30) @(negedge clock);
    `CHK(txMsg, idleMsg)
    finish_test();
  end
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
endmodule // sc1_maintenance_msg_scheduler_test
